// ---- verilog/swp_slave.sv ----
/*
  Bit-level slave of a single-wire open-drain pulse-width bus, plus its
  two-entry output buffer. Assumes swd_in is synchronous to ref_clk and
  that the pad resolves swd_out/swd_oe_n into the wire.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_buf #(
  parameter int W = 4,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : swp_buf

module swp_slave import swp_pkg::*; #(
  parameter int unsigned TH_D0_D1 = TH_D0_D1_CYC,
  parameter int unsigned TH_D1_START = TH_D1_START_CYC,
  parameter int unsigned TH_START_ATN = TH_START_ATN_CYC,
  parameter int unsigned TH_ATN_RST = TH_ATN_RST_CYC,
  parameter int unsigned RD1_CYC = READ_ONE_CYC,
  parameter int unsigned ATN_CYC = ATTENTION_CYC,
  parameter int unsigned RST_CYC = RESET_DRIVE_CYC,
  parameter logic [2:0] ADDR_LOW = ADDR_PIN_LOW,
  parameter logic [2:0] ADDR_HIGH = ADDR_PIN_HIGH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic swd_in,
  output logic swd_out,
  output logic swd_oe_n,
  input wire logic addr_sel,
  output logic [2:0] dev_addr,
  input wire logic rd_arm,
  input wire logic rd_one,
  input wire logic atn_req,
  output logic atn_busy,
  output logic atn_allowed,
  output logic bus_idle,
  output logic start_seen,
  output logic reset_seen,
  output logic overrun,
  output logic rx_valid,
  input wire logic rx_ready,
  output swp_word_type rx_data
);

  logic line_r;
  logic prev_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] high_cnt_r;
  logic [CNT_W-1:0] drv_cnt_r;
  logic [3:0] supp_cnt_r;
  logic own_r;
  logic strap_r;
  logic start_r;
  logic reset_r;
  logic overrun_r;
  logic [2:0] addr_r;
  swp_drv_type drv_state_r;
  swp_drv_type drv_state_nxt;
  logic fell;
  logic rose;
  logic idle;
  logic in_window;
  logic go_atn;
  logic go_rd1;
  logic drv_done;
  logic sym_valid;
  logic sym_ready;
  swp_word_type sym_nxt;

  // Line sampling and edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      line_r <= swd_in;
      prev_r <= line_r;
    end
  end

  assign fell = prev_r && !line_r;
  assign rose = !prev_r && line_r;

  // Low time of the current pulse, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (fell) begin
      low_cnt_r <= CNT_W'(1);
    end else if (!line_r && low_cnt_r != '1) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  // High time since the last pulse, saturating at the idle mark
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_cnt_r <= '0;
    end else if (!line_r) begin
      high_cnt_r <= '0;
    end else if (high_cnt_r < CNT_W'(MIN_IDLE_CYC)) begin
      high_cnt_r <= high_cnt_r + 1'b1;
    end
  end

  assign idle = line_r && (high_cnt_r >= CNT_W'(MIN_IDLE_CYC));
  assign in_window = !line_r && (low_cnt_r < CNT_W'(DETECT_CYC)) && !own_r;

  // Classification at the rising edge ending each pulse
  always_comb begin
    sym_nxt.own_drive = own_r;
    if (low_cnt_r >= CNT_W'(TH_ATN_RST)) begin
      sym_nxt.kind = SYM_RST;
    end else if (low_cnt_r >= CNT_W'(TH_START_ATN)) begin
      sym_nxt.kind = SYM_ATN;
    end else if (low_cnt_r >= CNT_W'(TH_D1_START)) begin
      sym_nxt.kind = SYM_START;
    end else if (low_cnt_r >= CNT_W'(TH_D0_D1)) begin
      sym_nxt.kind = SYM_D1;
    end else begin
      sym_nxt.kind = SYM_D0;
    end
  end

  assign sym_valid = rose;

  // Remember that our own drive shaped this pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      own_r <= 1'b0;
    end else if (rose) begin
      own_r <= 1'b0;
    end else if (drv_state_r != DRV_IDLE) begin
      own_r <= 1'b1;
    end
  end

  // Event pulses and lost-word flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_r <= 1'b0;
      reset_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      start_r <= rose && (sym_nxt.kind == SYM_START);
      reset_r <= rose && (sym_nxt.kind == SYM_RST);
      if (sym_valid && !sym_ready) begin
        overrun_r <= 1'b1;
      end
    end
  end

  // Attention suppression after a bus reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      supp_cnt_r <= SUPPRESS_BITS;
    end else if (rose && sym_nxt.kind == SYM_RST) begin
      supp_cnt_r <= SUPPRESS_BITS;
    end else if (rose && supp_cnt_r != 4'h0 && !own_r &&
                 (sym_nxt.kind == SYM_D0 || sym_nxt.kind == SYM_D1)) begin
      supp_cnt_r <= supp_cnt_r - 4'h1;
    end
  end

  // Address strap taken on the first clock after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_r <= 1'b0;
      addr_r <= 3'h0;
    end else if (!strap_r) begin
      strap_r <= 1'b1;
      addr_r <= addr_sel ? ADDR_HIGH : ADDR_LOW;
    end
  end

  // Drive sequencer
  assign atn_allowed = (supp_cnt_r == 4'h0);
  assign go_atn = atn_req && atn_allowed && (idle || in_window);
  assign go_rd1 = fell && rd_arm && rd_one && !go_atn;
  assign drv_done = (drv_state_r == DRV_POR && drv_cnt_r == CNT_W'(RST_CYC - 1)) ||
                    (drv_state_r == DRV_RD1 && drv_cnt_r == CNT_W'(RD1_CYC - 1)) ||
                    (drv_state_r == DRV_ATN && drv_cnt_r == CNT_W'(ATN_CYC - 1));

  always_comb begin
    drv_state_nxt = drv_state_r;
    case (drv_state_r)
      DRV_POR: begin
        if (drv_done) begin
          drv_state_nxt = DRV_IDLE;
        end
      end
      DRV_IDLE: begin
        if (go_atn) begin
          drv_state_nxt = DRV_ATN;
        end else if (go_rd1) begin
          drv_state_nxt = DRV_RD1;
        end
      end
      DRV_RD1: begin
        if (drv_done) begin
          drv_state_nxt = DRV_IDLE;
        end
      end
      DRV_ATN: begin
        if (drv_done) begin
          drv_state_nxt = DRV_IDLE;
        end
      end
      default: begin
        drv_state_nxt = DRV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drv_state_r <= DRV_POR;
    end else begin
      drv_state_r <= drv_state_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drv_cnt_r <= '0;
    end else if (drv_state_nxt != drv_state_r) begin
      drv_cnt_r <= '0;
    end else if (drv_state_r != DRV_IDLE) begin
      drv_cnt_r <= drv_cnt_r + 1'b1;
    end
  end

  assign swd_out = 1'b0;
  assign swd_oe_n = (drv_state_r == DRV_IDLE);
  assign atn_busy = (drv_state_r == DRV_ATN);
  assign bus_idle = idle;
  assign start_seen = start_r;
  assign reset_seen = reset_r;
  assign overrun = overrun_r;
  assign dev_addr = addr_r;

  swp_buf #(
    .W($bits(swp_word_type)),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(sym_valid),
    .in_ready(sym_ready),
    .in_data(sym_nxt),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_rd1_trigger;
    drv_state_r == DRV_IDLE && go_rd1;
  endsequence

  sequence s_drive_low;
    drv_state_r == DRV_RD1 && !swd_oe_n;
  endsequence

  sequence s_atn_entry;
    drv_state_r == DRV_IDLE ##1 drv_state_r == DRV_ATN;
  endsequence

  chk_rd1_start: assert property (s_rd1_trigger |=> s_drive_low [*8])
    else $error("read-one drive did not start after falling edge");

  chk_rd1_width: assert property (
    ($past(drv_state_r) == DRV_RD1 && drv_state_r == DRV_IDLE) |->
      $past(drv_cnt_r) == CNT_W'(RD1_CYC - 1))
    else $error("read-one drive width wrong");

  chk_atn_suppress: assert property (s_atn_entry |-> $past(supp_cnt_r) == 4'h0)
    else $error("attention started while suppressed");

  chk_atn_gate: assert property (
    s_atn_entry |-> $past(idle) || $past(in_window))
    else $error("attention started outside idle or detect window");

  chk_reset_reload: assert property (
    (rose && low_cnt_r >= CNT_W'(TH_ATN_RST)) |=>
      supp_cnt_r == SUPPRESS_BITS && reset_seen ##1 !reset_seen)
    else $error("reset pulse not recognised");

  chk_short_data: assert property (
    (rose && low_cnt_r < CNT_W'(TH_D0_D1)) |->
      sym_valid && sym_nxt.kind == SYM_D0 ##1 !start_seen)
    else $error("short pulse not taken as zero");

  chk_start_detect: assert property (
    (rose && low_cnt_r >= CNT_W'(TH_D1_START) && low_cnt_r < CNT_W'(TH_START_ATN)) |=>
      start_seen)
    else $error("start pulse missed");

  chk_atn_not_start: assert property (
    (rose && low_cnt_r >= CNT_W'(TH_START_ATN)) |=> !start_seen)
    else $error("long pulse taken as start");

  chk_idle_wait: assert property (rose |=> !bus_idle [*8])
    else $error("idle flagged too soon after a pulse");

  chk_por_drive: assert property (
    (drv_state_r == DRV_POR && drv_cnt_r == '0) |-> !swd_oe_n [*8])
    else $error("power-up reset not driven");

endmodule : swp_slave
`default_nettype wire

// ---- verilog/swp_pkg.sv ----
/*
  Constants, timing counts and carrier types for the single-wire
  pulse-width slave. Assumes a 250 MHz clock; all pulse figures in us.
*/
`default_nettype none
package swp_pkg;

  localparam real CLK_MHZ = 250.0;

  // Pulse figures in microseconds
  localparam real MIN_IDLE_TIME_US = 11.0;
  localparam real ACTIVITY_DETECT_WINDOW_US = 9.6;
  localparam real MASTER_SHORT_PULSE_MAX_US = 17.0;
  localparam real MASTER_LONG_PULSE_MIN_US = 35.4;
  localparam real MASTER_LONG_PULSE_MAX_US = 48.9;
  localparam real SLAVE_READ_ONE_MIN_US = 28.3;
  localparam real SLAVE_READ_ONE_MAX_US = 38.3;
  localparam real START_PULSE_MIN_US = 80.0;
  localparam real START_PULSE_MAX_US = 109.0;
  localparam real ATTENTION_PULSE_MIN_US = 165.0;
  localparam real ATTENTION_PULSE_MAX_US = 228.0;
  localparam real RESET_PULSE_MIN_US = 354.0;

  // Class boundaries lie midway between neighbouring widths
  localparam real TH_D0_D1_US = (MASTER_SHORT_PULSE_MAX_US + MASTER_LONG_PULSE_MIN_US) / 2.0;
  localparam real TH_D1_START_US = (MASTER_LONG_PULSE_MAX_US + START_PULSE_MIN_US) / 2.0;
  localparam real TH_START_ATN_US = (START_PULSE_MAX_US + ATTENTION_PULSE_MIN_US) / 2.0;
  localparam real TH_ATN_RST_US = (ATTENTION_PULSE_MAX_US + RESET_PULSE_MIN_US) / 2.0;
  localparam real READ_ONE_NOM_US = (SLAVE_READ_ONE_MIN_US + SLAVE_READ_ONE_MAX_US) / 2.0;
  localparam real ATTENTION_NOM_US = (ATTENTION_PULSE_MIN_US + ATTENTION_PULSE_MAX_US) / 2.0;

  function automatic int cyc_least(input real us);
    int c;
    c = int'($ceil(us * CLK_MHZ));
    return (c < 1) ? 1 : c;
  endfunction : cyc_least

  function automatic int cyc_most(input real us);
    int c;
    c = int'($floor(us * CLK_MHZ));
    return (c < 1) ? 1 : c;
  endfunction : cyc_most

  localparam int MIN_IDLE_CYC = cyc_least(MIN_IDLE_TIME_US);
  localparam int DETECT_CYC = cyc_most(ACTIVITY_DETECT_WINDOW_US);
  localparam int TH_D0_D1_CYC = cyc_most(TH_D0_D1_US);
  localparam int TH_D1_START_CYC = cyc_most(TH_D1_START_US);
  localparam int TH_START_ATN_CYC = cyc_most(TH_START_ATN_US);
  localparam int TH_ATN_RST_CYC = cyc_most(TH_ATN_RST_US);
  localparam int READ_ONE_CYC = cyc_most(READ_ONE_NOM_US);
  localparam int ATTENTION_CYC = cyc_most(ATTENTION_NOM_US);
  localparam int RESET_DRIVE_CYC = cyc_least(RESET_PULSE_MIN_US);

  localparam int CNT_W = 17;
  localparam logic [3:0] SUPPRESS_BITS = 4'hE;
  localparam logic [2:0] ADDR_PIN_LOW = 3'h1;
  localparam logic [2:0] ADDR_PIN_HIGH = 3'h2;

  typedef enum logic [2:0] {
    SYM_D0 = 3'h0,
    SYM_D1 = 3'h1,
    SYM_START = 3'h2,
    SYM_ATN = 3'h3,
    SYM_RST = 3'h4
  } swp_sym_type;

  typedef enum logic [1:0] {
    DRV_POR = 2'h3,
    DRV_IDLE = 2'h0,
    DRV_RD1 = 2'h1,
    DRV_ATN = 2'h2
  } swp_drv_type;

  typedef struct packed {
    swp_sym_type kind;
    logic own_drive;
  } swp_word_type;

endpackage : swp_pkg
`default_nettype wire

// ---- test/swp_master_model.sv ----
/*
  Behavioural bus master for the single-wire pulse-width link.
  Assumes an external pull-up: the wire is low while mst_oe_n is low.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_master_model import swp_pkg::*; #(
  parameter int IDLE_CYC = 2800
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic line_in,
  input wire logic go,
  input wire logic [15:0] width,
  output logic mst_oe_n,
  output logic busy
);
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;
  logic [15:0] width_r;
  logic wait_r;
  logic drive_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_cnt_r <= 16'h0;
    end else if (!line_in) begin
      hi_cnt_r <= 16'h0;
    end else if (hi_cnt_r != 16'hFFFF) begin
      hi_cnt_r <= hi_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      wait_r <= 1'b0;
      drive_r <= 1'b0;
      lo_cnt_r <= 16'h0;
      width_r <= 16'h0;
    end else if (go) begin
      busy <= 1'b1;
      wait_r <= 1'b1;
      width_r <= width;
    end else if (wait_r && hi_cnt_r >= IDLE_CYC) begin
      wait_r <= 1'b0;
      drive_r <= 1'b1;
      lo_cnt_r <= 16'h1;
    end else if (drive_r && lo_cnt_r >= width_r) begin
      drive_r <= 1'b0;
      busy <= 1'b0;
    end else if (drive_r) begin
      lo_cnt_r <= lo_cnt_r + 16'h1;
    end
  end

  assign mst_oe_n = ~drive_r;
endmodule : swp_master_model
`default_nettype wire

// ---- test/swp_slave_tb.sv ----
/*
  Self-checking bench for swp_slave with shortened pulse thresholds.
  Assumes the master model and a pulled-up open-drain wire.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_slave_tb import swp_pkg::*; ;
  localparam int TH0 = 20;
  localparam int TH1 = 40;
  localparam int TH2 = 60;
  localparam int TH3 = 80;
  logic ref_clk, rst, swd, swd_out, swd_oe_n, addr_sel;
  logic [2:0] dev_addr;
  logic rd_arm, rd_one, atn_req, atn_busy, atn_allowed, bus_idle;
  logic start_seen, reset_seen, overrun, rx_valid, rx_ready;
  swp_word_type rx_data;
  logic go, mst_oe_n, mst_busy;
  logic [15:0] width;
  int n_fail, n_checks, n_start, n_rst, seed, w, k;

  swp_slave #(.TH_D0_D1(TH0), .TH_D1_START(TH1), .TH_START_ATN(TH2), .TH_ATN_RST(TH3),
    .RD1_CYC(30), .ATN_CYC(70), .RST_CYC(100)) swp_slave_inst (
    .ref_clk(ref_clk), .rst(rst), .swd_in(swd), .swd_out(swd_out), .swd_oe_n(swd_oe_n),
    .addr_sel(addr_sel), .dev_addr(dev_addr), .rd_arm(rd_arm), .rd_one(rd_one),
    .atn_req(atn_req), .atn_busy(atn_busy), .atn_allowed(atn_allowed), .bus_idle(bus_idle),
    .start_seen(start_seen), .reset_seen(reset_seen), .overrun(overrun),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

  swp_master_model swp_master_model_inst (.ref_clk(ref_clk), .rst(rst), .line_in(swd),
    .go(go), .width(width), .mst_oe_n(mst_oe_n), .busy(mst_busy));

  // Pull-up wire: low whenever either party pulls it
  assign swd = swd_oe_n & mst_oe_n;

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (start_seen === 1'b1) n_start++;
    if (reset_seen === 1'b1) n_rst++;
  end

  function automatic swp_sym_type exp_kind(input int lo);
    if (lo < TH0) return SYM_D0;
    if (lo < TH1) return SYM_D1;
    if (lo < TH2) return SYM_START;
    if (lo < TH3) return SYM_ATN;
    return SYM_RST;
  endfunction : exp_kind

  task automatic cmp_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_sym(input swp_word_type exp);
    n_checks++;
    if (rx_data !== exp) begin
      n_fail++;
      $display("[ERR] rx_data expected %h seen %h", exp, rx_data);
    end
  endtask : cmp_sym

  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Master pulse of lo cycles, returns once the master has released
  task automatic pulse(input int lo);
    int i;
    i = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    width <= lo[15:0];
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    while (mst_busy !== 1'b0 && i < 10000) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
  endtask : pulse

  // Waits for a buffered symbol, compares it and pops it
  task automatic get_sym(input swp_sym_type kind, input logic own);
    int i;
    swp_word_type e;
    i = 0;
    e.kind = kind;
    e.own_drive = own;
    while (rx_valid !== 1'b1 && i < 20000) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    cmp_sym(e);
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    @(posedge ref_clk);
    rx_ready <= 1'b0;
    #1;
  endtask : get_sym

  initial begin
    repeat (95000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    seed = 32'h32f4;
    addr_sel = 1'($random(seed));
    {rd_arm, rd_one, atn_req, rx_ready, go} = 5'h0;
    width = 16'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_val("dev_addr", 8'(addr_sel ? ADDR_PIN_HIGH : ADDR_PIN_LOW), 8'(dev_addr));
    cmp_val("swd_out", 8'h0, 8'(swd_out));
    get_sym(SYM_RST, 1'b1);
    cmp_val("reset_seen", 8'h1, n_rst[7:0]);
    cmp_val("overrun", 8'h0, 8'(overrun));
    // Master's own power-up reset
    pulse(90);
    get_sym(SYM_RST, 1'b0);
    cmp_val("reset_seen", 8'h2, n_rst[7:0]);
    // Attention wished for throughout the suppressed span
    @(posedge ref_clk);
    atn_req <= 1'b1;
    #1;
    for (k = 0; k < 14; k++) begin
      w = (k < 8) ? 10 : 5 + ($unsigned($random(seed)) % 31);
      if (w == TH0 - 1) w = TH0;
      cmp_val("atn_allowed", 8'h0, 8'(atn_allowed));
      cmp_val("atn_busy", 8'h0, 8'(atn_busy));
      pulse(w);
      get_sym(exp_kind(w), 1'b0);
    end
    @(posedge ref_clk);
    atn_req <= 1'b0;
    #1;
    cmp_val("atn_allowed", 8'h1, 8'(atn_allowed));
    cmp_val("bus_idle", 8'h0, 8'(bus_idle));
    pulse(50);
    get_sym(SYM_START, 1'b0);
    cmp_val("start_seen", 8'h1, n_start[7:0]);
    @(posedge ref_clk);
    rd_arm <= 1'b1;
    rd_one <= 1'b1;
    pulse(10);
    get_sym(SYM_D1, 1'b1);
    @(posedge ref_clk);
    rd_one <= 1'b0;
    pulse(10);
    get_sym(SYM_D0, 1'b0);
    @(posedge ref_clk);
    rd_arm <= 1'b0;
    // Idle must appear only after the minimum high time
    repeat (MIN_IDLE_CYC - 8) @(posedge ref_clk);
    #1;
    cmp_val("bus_idle", 8'h0, 8'(bus_idle));
    repeat (12) @(posedge ref_clk);
    #1;
    cmp_val("bus_idle", 8'h1, 8'(bus_idle));
    @(posedge ref_clk);
    atn_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_val("atn_busy", 8'h1, 8'(atn_busy));
    @(posedge ref_clk);
    atn_req <= 1'b0;
    get_sym(SYM_ATN, 1'b1);
    repeat (3) pulse(10);
    repeat (4) @(posedge ref_clk);
    #1;
    cmp_val("overrun", 8'h1, 8'(overrun));
    get_sym(SYM_D0, 1'b0);
    get_sym(SYM_D0, 1'b0);
    cmp_val("rx_valid", 8'h0, 8'(rx_valid));
    // Attention raised inside the detect window of a master start
    fork
      pulse(50);
      begin
        while (swd !== 1'b0) @(posedge ref_clk);
        @(posedge ref_clk);
        atn_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        atn_req <= 1'b0;
        #1;
        cmp_val("atn_busy", 8'h1, 8'(atn_busy));
      end
    join
    get_sym(SYM_ATN, 1'b1);
    cmp_val("start_seen", 8'h1, n_start[7:0]);
    pulse(90);
    get_sym(SYM_RST, 1'b0);
    cmp_val("reset_seen", 8'h3, n_rst[7:0]);
    cmp_val("atn_allowed", 8'h0, 8'(atn_allowed));
    cmp_val("dev_addr", 8'(addr_sel ? ADDR_PIN_HIGH : ADDR_PIN_LOW), 8'(dev_addr));
    wrap_up();
  end
endmodule : swp_slave_tb
`default_nettype wire
